// [hw/phy_ext_control_and_pkt_gen.sv]
// Extended pad, wake and packet self-test control of the PHY
// What this block does
// - Strap high routes general or wake interrupt to status pin by select.
// - Two drive strength fields, media default 2, used only outside scan.
// - Jitter test bit puts DAC clock on receive clock output.
// - Shape field bit 0 picks pulse (1) or level (0) wake interrupt.
// - Upper shape bits pick pulse width 10us, 100us, 1ms or 10ms.
// - Isolate with TX control set makes TX_CLK input, else keep direction.
// - Isolate with RX control set makes RX_CLK input, else keep direction.
// - Wake MAC address in three word registers, high word first.
// - Checker enable turns receive and transmit checkers on or off.
// - Gating bit gates self-test clocks when checker off, normal, gen off.
// - Test select one sends MAC data, zero sends generator data.
// - Generator enable starts packets; they reach pads only in test mode.
// - Burst zero runs until cleared, else stops and clears enable.
// - Preamble length from four-bit field, default 8, below 2 ignored.
// - Gap length from four-bit field, default 12, below 2 ignored.
// - Force bit lets packets out without link, otherwise link needed.
// - Corrupt bit makes frame check sequence bad, else correct.
// - Payload incrementing, random, or fixed 5aa55aa5; code 3 reserved.
// - Packet length register, sixteen bits, default 64.
// - Burst count register, sixteen bits, default 0.
`default_nettype none
module phy_ext_control_and_pkt_gen #(
	parameter int unsigned WAKE_100US_CYC = phy_ext_pkg::WAKE_100US_CYC,
	parameter int unsigned WAKE_1MS_CYC   = phy_ext_pkg::WAKE_1MS_CYC,
	parameter int unsigned WAKE_10MS_CYC  = phy_ext_pkg::WAKE_10MS_CYC
) (
	input  wire logic                  clk_i,
	input  wire logic                  rst_b_i,
	input  wire phy_ext_pkg::reg_req_t reg_req_i,
	output logic [15:0]                reg_rdata_o,
	input  wire logic                  isolate_i,
	input  wire logic                  clk_pins_input_i,
	input  wire logic                  scan_mode_i,
	input  wire logic                  link_up_i,
	input  wire logic                  general_irq_i,
	input  wire logic                  wake_event_i,
	input  wire logic                  wake_ack_i,
	input  wire logic                  receive_data_bit1_strap_i,
	input  wire logic                  dac_clk_i,
	input  wire logic                  rx_clk_src_i,
	input  wire logic                  tx_clk_i,
	input  wire phy_ext_pkg::mii_tx_t  mac_tx_i,
	output phy_ext_pkg::mii_tx_t       pad_tx_o,
	output logic                       rx_clk_o,
	output logic                       tx_clk_oe_o,
	output logic                       rx_clk_oe_o,
	output logic                       status_light_pin_o,
	output logic [1:0]                 media_if_drive_strength_o,
	output logic [1:0]                 mgmt_pin_drive_strength_o,
	output logic [47:0]                wake_match_addr_o,
	output logic                       rx_checker_en_o,
	output logic                       tx_checker_en_o,
	output logic                       selftest_clk_gate_o
);
	import phy_ext_pkg::*;

	state_t      s;
	state_t      n;
	logic [15:0] rd_val;
	logic        te;
	logic        tx_ok;
	logic        gen_done;
	logic        st_wr;
	logic        pulse;
	logic [1:0]  width;
	logic        wake_out;
	logic [7:0]  byte_v;
	logic [7:0]  pre_byte;
	logic [3:0]  nib_v;
	logic [3:0]  fcs_nib;
	logic [31:0] fcs;
	logic [16:0] pre_last;
	logic [16:0] data_last;
	logic [16:0] gap_last;
	payload_t    pl;

	// Reflected CRC-32 over one nibble, low bit first
	function automatic logic [31:0] crc_nib(input logic [31:0] c,
		input logic [3:0] d);
		logic [31:0] r;
		r = c;
		for (int i = 0; i < 4; i++) begin
			r = (r[0] ^ d[i]) ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
		end
		return r;
	endfunction

	// Next state of the whole block
	always_comb begin
		n = s;
		rd_val = '0;
		gen_done = 1'b0;
		pre_byte = PREAMBLE_BYTE;
		fcs = ~s.crc;
		fcs_nib = fcs[{s.idx[2:0], 2'b00} +: 4];
		pre_last = {12'h000, s.pre_eff, 1'b0} - 17'd1;
		data_last = {s.len, 1'b0} - 17'd1;
		gap_last = {12'h000, s.gap_eff, 1'b0} - 17'd1;
		st_wr = reg_req_i.wr && (reg_req_i.addr == SELFTEST_OFS);
		te = s.txc[1] & ~s.txc[2];
		tx_ok = s.st_ctl[FORCE_BIT] | link_up_i;
		pl = payload_t'(s.st_ctl[PAYLOAD_LSB +: 2]);
		pulse = s.combo2[SHAPE_LSB];
		width = s.combo2[SHAPE_LSB + 1 +: 2];
		wake_out = pulse ? (s.wake_cnt != '0) : s.wake_lvl;

		// Synchronisers for pins and the link clock
		n.txc = {s.txc[1:0], tx_clk_i};
		n.mac_s0 = mac_tx_i;
		n.mac_s1 = s.mac_s0;
		n.strap_s = {s.strap_s[0], receive_data_bit1_strap_i};
		n.strap_vld = {s.strap_vld[0], 1'b1};
		if (s.strap_vld[1] && !s.strap_done) begin
			n.strap = s.strap_s[1];
			n.strap_done = 1'b1;
		end

		// Payload byte selection
		case (pl)
			PL_INC:   byte_v = s.idx[8:1];
			PL_RAND:  byte_v = s.lfsr;
			PL_FIXED: byte_v = FIXED_PATTERN[{~s.idx[2:1], 3'b000} +: 8];
			default:  byte_v = '0;
		endcase
		nib_v = s.idx[0] ? byte_v[7:4] : byte_v[3:0];

		// Smallest accepted preamble and gap
		if (s.st_ctl[PRE_LSB +: 4] >= MIN_FIELD) begin
			n.pre_eff = s.st_ctl[PRE_LSB +: 4];
		end
		if (s.st_ctl[GAP_LSB +: 4] >= MIN_FIELD) begin
			n.gap_eff = s.st_ctl[GAP_LSB +: 4];
		end

		// Packet generator, one nibble per rising link clock edge
		if (te) begin
			n.idx = s.idx + 17'd1;
			case (s.gst)
				G_IDLE: begin
					n.gen_tx = '0;
					n.idx = '0;
					if (!s.st_ctl[GEN_EN_BIT]) begin
						n.pkts = '0;
					end
					if (s.st_ctl[GEN_EN_BIT] && tx_ok) begin
						n.gst = G_PRE;
						n.crc = CRC_INIT;
					end
				end
				G_PRE: begin
					if (s.idx[16:1] == pre_last[16:1]) begin
						pre_byte = SFD_BYTE;
					end
					n.gen_tx.en = 1'b1;
					n.gen_tx.d = s.idx[0] ? pre_byte[7:4] : pre_byte[3:0];
					if (s.idx == pre_last) begin
						n.gst = G_DATA;
						n.idx = '0;
					end
				end
				G_DATA: begin
					n.gen_tx.en = 1'b1;
					n.gen_tx.d = nib_v;
					n.crc = crc_nib(s.crc, nib_v);
					if (s.idx[0] && pl == PL_RAND) begin
						n.lfsr = {s.lfsr[6:0],
							s.lfsr[7] ^ s.lfsr[5] ^ s.lfsr[4] ^ s.lfsr[3]};
					end
					if (s.idx == data_last) begin
						n.gst = G_FCS;
						n.idx = '0;
					end
				end
				G_FCS: begin
					n.gen_tx.en = 1'b1;
					n.gen_tx.d = fcs_nib;
					if (s.st_ctl[BAD_FCS_BIT] && s.idx == '0) begin
						n.gen_tx.d = ~fcs_nib;
					end
					if (s.idx == 17'd7) begin
						n.gst = G_GAP;
						n.idx = '0;
						n.pkts = s.pkts + 16'd1;
						if (s.burst != '0 && n.pkts == s.burst) begin
							gen_done = 1'b1;
						end
					end
				end
				G_GAP: begin
					n.gen_tx = '0;
					if (s.idx == gap_last) begin
						n.gst = G_IDLE;
						n.idx = '0;
					end
				end
				default: begin
					n.gst = G_IDLE;
					n.gen_tx = '0;
				end
			endcase
		end

		// A fresh enable starts a new burst count
		if (st_wr && reg_req_i.wdata[GEN_EN_BIT] &&
			!s.st_ctl[GEN_EN_BIT]) begin
			n.pkts = '0;
		end
		// Register writes
		if (reg_req_i.wr) begin
			case (reg_req_i.addr)
				PAD_CTRL_OFS: n.pad = reg_req_i.wdata;
				CLK_WAKE_OFS: n.combo2 = reg_req_i.wdata;
				WAKE_HI_OFS:  n.mac_h = reg_req_i.wdata;
				WAKE_MID_OFS: n.mac_m = reg_req_i.wdata;
				WAKE_LO_OFS:  n.mac_l = reg_req_i.wdata;
				SELFTEST_OFS: n.st_ctl = reg_req_i.wdata;
				PKT_LEN_OFS:  n.len = reg_req_i.wdata;
				BURST_OFS:    n.burst = reg_req_i.wdata;
				default: ;
			endcase
		end
		// Self clear at burst end; a software write that cycle wins
		if (gen_done && !st_wr) begin
			n.st_ctl[GEN_EN_BIT] = 1'b0;
		end

		// Register reads, answered on the next edge
		case (reg_req_i.addr)
			PAD_CTRL_OFS: rd_val = s.pad;
			CLK_WAKE_OFS: rd_val = s.combo2;
			WAKE_HI_OFS:  rd_val = s.mac_h;
			WAKE_MID_OFS: rd_val = s.mac_m;
			WAKE_LO_OFS:  rd_val = s.mac_l;
			SELFTEST_OFS: rd_val = s.st_ctl;
			PKT_LEN_OFS:  rd_val = s.len;
			BURST_OFS:    rd_val = s.burst;
			default:      rd_val = '0;
		endcase
		if (reg_req_i.rd) begin
			n.rdata = rd_val;
		end

		// Transmit source select
		n.pad_tx = s.st_ctl[TEST_SEL_BIT] ? s.mac_s1 : s.gen_tx;
		// Checker enables and self-test clock gating
		n.chk = s.st_ctl[CHK_EN_BIT];
		n.gate = s.st_ctl[GATE_EN_BIT] & ~s.st_ctl[CHK_EN_BIT] &
			s.st_ctl[TEST_SEL_BIT] & ~s.st_ctl[GEN_EN_BIT];
		// Drive strengths fall back to defaults in scan
		n.drv_mi = scan_mode_i ? PAD_CTRL_RST[MI_DRV_LSB +: 2] :
			s.pad[MI_DRV_LSB +: 2];
		n.drv_md = scan_mode_i ? PAD_CTRL_RST[MD_DRV_LSB +: 2] :
			s.pad[MD_DRV_LSB +: 2];

		// Wake interrupt shaping; an event beats an acknowledge
		if (s.wake_cnt != '0) begin
			n.wake_cnt = s.wake_cnt - 19'd1;
		end
		if (wake_ack_i) begin
			n.wake_lvl = 1'b0;
		end
		if (wake_event_i) begin
			if (pulse) begin
				case (width)
					2'b00:   n.wake_cnt = WAKE_10US_LD;
					2'b01:   n.wake_cnt = 19'(WAKE_100US_CYC);
					2'b10:   n.wake_cnt = 19'(WAKE_1MS_CYC);
					default: n.wake_cnt = 19'(WAKE_10MS_CYC);
				endcase
			end else begin
				n.wake_lvl = 1'b1;
			end
		end
		// Status pin carries an interrupt only when strapped for it
		n.pin = s.strap & (s.pad[IRQ_SRC_BIT] ? general_irq_i :
			wake_out);

		// Clock pin directions under isolate
		if (!isolate_i) begin
			n.txdir_in = clk_pins_input_i;
			n.rxdir_in = clk_pins_input_i;
		end else begin
			if (s.combo2[TXC_ISO_BIT]) begin
				n.txdir_in = 1'b1;
			end
			if (s.combo2[RXC_ISO_BIT]) begin
				n.rxdir_in = 1'b1;
			end
		end
	end

	// State register
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			s <= STATE_RST;
		end else begin
			s <= n;
		end
	end

	// Outputs
	assign reg_rdata_o = s.rdata;
	assign pad_tx_o = s.pad_tx;
	// Plain clock mux, glitches possible when the bit changes
	assign rx_clk_o = s.combo2[JITTER_BIT] ? dac_clk_i : rx_clk_src_i;
	assign tx_clk_oe_o = ~s.txdir_in;
	assign rx_clk_oe_o = ~s.rxdir_in;
	assign status_light_pin_o = s.pin;
	assign media_if_drive_strength_o = s.drv_mi;
	assign mgmt_pin_drive_strength_o = s.drv_md;
	assign wake_match_addr_o = {s.mac_h, s.mac_m, s.mac_l};
	assign rx_checker_en_o = s.chk;
	assign tx_checker_en_o = s.chk;
	assign selftest_clk_gate_o = s.gate;

	// Checks
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_b_i);

	property p_irq_general;
		s.strap && s.pad[IRQ_SRC_BIT] |=>
			status_light_pin_o == $past(general_irq_i);
	endproperty
	a_irq_general: assert property (p_irq_general)
		else $error("status pin not following general irq");
	property p_drv_scan;
		scan_mode_i |=> media_if_drive_strength_o == 2'h2;
	endproperty
	a_drv_scan: assert property (p_drv_scan)
		else $error("media drive not default in scan");
	property p_jitter;
		s.combo2[JITTER_BIT] |-> rx_clk_o == dac_clk_i;
	endproperty
	a_jitter: assert property (p_jitter)
		else $error("dac clock not on receive clock");
	property p_wake_level;
		s.strap && !s.pad[IRQ_SRC_BIT] && !pulse && wake_event_i &&
			!$changed(s.pad) |=> ##1 status_light_pin_o;
	endproperty
	a_wake_level: assert property (p_wake_level)
		else $error("wake level missing on status pin");
	property p_wake_width;
		pulse && width == 2'b00 && wake_event_i |=>
			s.wake_cnt == 19'd500;
	endproperty
	a_wake_width: assert property (p_wake_width)
		else $error("wake pulse width wrong");
	property p_txc_iso;
		isolate_i && s.combo2[TXC_ISO_BIT] |=> !tx_clk_oe_o;
	endproperty
	a_txc_iso: assert property (p_txc_iso)
		else $error("tx clock not input under isolate");
	property p_rxc_keep;
		isolate_i && !s.combo2[RXC_ISO_BIT] |=> $stable(rx_clk_oe_o);
	endproperty
	a_rxc_keep: assert property (p_rxc_keep)
		else $error("rx clock direction changed under isolate");
	property p_gate;
		s.st_ctl[15:12] == 4'b0110 |=> selftest_clk_gate_o;
	endproperty
	a_gate: assert property (p_gate)
		else $error("self-test clocks not gated");
	property p_pad_mac;
		s.st_ctl[TEST_SEL_BIT] |=> pad_tx_o == $past(s.mac_s1);
	endproperty
	a_pad_mac: assert property (p_pad_mac)
		else $error("pads not carrying mac data");
	property p_burst_stop;
		gen_done && !st_wr |=> !s.st_ctl[GEN_EN_BIT];
	endproperty
	a_burst_stop: assert property (p_burst_stop)
		else $error("generator enable not cleared after burst");
	property p_no_link;
		s.gst == G_IDLE && !tx_ok |=> s.gst == G_IDLE;
	endproperty
	a_no_link: assert property (p_no_link)
		else $error("generator started without link");
	property p_pre_min;
		s.pre_eff >= 4'h2 && s.gap_eff >= 4'h2;
	endproperty
	a_pre_min: assert property (p_pre_min)
		else $error("preamble or gap below two bytes");
	c_gap: cover property (s.gst == G_FCS ##1 s.gst == G_GAP);
	c_burst: cover property (gen_done);
	c_bad_fcs: cover property (s.gst == G_FCS && s.st_ctl[BAD_FCS_BIT]);
	c_wake_pulse: cover property (pulse && s.wake_cnt == 19'd1);
endmodule
`default_nettype wire

// [shared/phy_ext_pkg.sv]
// Register map, reset values, timing and carrier types of the ext block
`default_nettype none
package phy_ext_pkg;
	// Register offsets
	localparam logic [15:0] PAD_CTRL_OFS = 16'h4001;
	localparam logic [15:0] CLK_WAKE_OFS = 16'h4003;
	localparam logic [15:0] WAKE_HI_OFS  = 16'h4004;
	localparam logic [15:0] WAKE_MID_OFS = 16'h4005;
	localparam logic [15:0] WAKE_LO_OFS  = 16'h4006;
	localparam logic [15:0] SELFTEST_OFS = 16'h40a0;
	localparam logic [15:0] PKT_LEN_OFS  = 16'h40a1;
	localparam logic [15:0] BURST_OFS    = 16'h40a2;
	// Values after reset
	localparam logic [15:0] PAD_CTRL_RST = 16'h80ef;
	localparam logic [15:0] CLK_WAKE_RST = 16'h0260;
	localparam logic [15:0] SELFTEST_RST = 16'h68c0;
	localparam logic [15:0] PKT_LEN_RST  = 16'h0040;
	localparam logic [15:0] BURST_RST    = 16'h0000;
	localparam logic [3:0]  PRE_RST      = 4'h8;
	localparam logic [3:0]  GAP_RST      = 4'hc;
	localparam logic [3:0]  MIN_FIELD    = 4'h2;
	localparam logic [7:0]  LFSR_SEED    = 8'h01;
	// Field positions
	localparam int IRQ_SRC_BIT  = 15;
	localparam int MI_DRV_LSB   = 4;
	localparam int MD_DRV_LSB   = 2;
	localparam int JITTER_BIT   = 14;
	localparam int SHAPE_LSB    = 7;
	localparam int TXC_ISO_BIT  = 6;
	localparam int RXC_ISO_BIT  = 5;
	localparam int CHK_EN_BIT   = 15;
	localparam int GATE_EN_BIT  = 14;
	localparam int TEST_SEL_BIT = 13;
	localparam int GEN_EN_BIT   = 12;
	localparam int PRE_LSB      = 8;
	localparam int GAP_LSB      = 4;
	localparam int FORCE_BIT    = 3;
	localparam int BAD_FCS_BIT  = 2;
	localparam int PAYLOAD_LSB  = 0;
	// Frame constants
	localparam logic [31:0] FIXED_PATTERN = 32'h5aa55aa5;
	localparam logic [7:0]  PREAMBLE_BYTE = 8'h55;
	localparam logic [7:0]  SFD_BYTE      = 8'hd5;
	localparam logic [31:0] CRC_INIT      = 32'hffffffff;
	localparam logic [31:0] CRC_POLY      = 32'hedb88320;
	// Wake pulse widths
	localparam int CLK_PERIOD_NS = 20;
	localparam int WAKE_10_US    = 10;
	localparam int WAKE_100_US   = 100;
	localparam int WAKE_1_MS     = 1;
	localparam int WAKE_10_MS    = 10;
	localparam int WAKE_10US_CYC  = WAKE_10_US * 1000 / CLK_PERIOD_NS;
	localparam int WAKE_100US_CYC = WAKE_100_US * 1000 / CLK_PERIOD_NS;
	localparam int WAKE_1MS_CYC   = WAKE_1_MS * 1000000 / CLK_PERIOD_NS;
	localparam int WAKE_10MS_CYC  = WAKE_10_MS * 1000000 / CLK_PERIOD_NS;
	localparam logic [18:0] WAKE_10US_LD = 19'(WAKE_10US_CYC);
	// Carriers
	typedef enum logic [1:0] {PL_INC, PL_RAND, PL_FIXED, PL_RSVD} payload_t;
	typedef enum logic [2:0] {G_IDLE, G_PRE, G_DATA, G_FCS, G_GAP} gen_state_t;
	typedef struct packed {
		logic [15:0] addr;
		logic [15:0] wdata;
		logic        wr;
		logic        rd;
	} reg_req_t;
	typedef struct packed {
		logic       en;
		logic [3:0] d;
	} mii_tx_t;
	typedef struct packed {
		logic [15:0] pad;
		logic [15:0] combo2;
		logic [15:0] st_ctl;
		logic [15:0] len;
		logic [15:0] burst;
		logic [15:0] mac_h;
		logic [15:0] mac_m;
		logic [15:0] mac_l;
		logic [15:0] rdata;
		logic [2:0]  txc;
		mii_tx_t     mac_s0;
		mii_tx_t     mac_s1;
		logic [1:0]  strap_s;
		logic [1:0]  strap_vld;
		logic        strap;
		logic        strap_done;
		gen_state_t  gst;
		logic [16:0] idx;
		logic [15:0] pkts;
		logic [31:0] crc;
		logic [7:0]  lfsr;
		logic [3:0]  pre_eff;
		logic [3:0]  gap_eff;
		mii_tx_t     gen_tx;
		mii_tx_t     pad_tx;
		logic        pin;
		logic        txdir_in;
		logic        rxdir_in;
		logic        wake_lvl;
		logic [18:0] wake_cnt;
		logic [1:0]  drv_mi;
		logic [1:0]  drv_md;
		logic        chk;
		logic        gate;
	} state_t;
	localparam state_t STATE_RST = '{pad: PAD_CTRL_RST,
		combo2: CLK_WAKE_RST, st_ctl: SELFTEST_RST, len: PKT_LEN_RST,
		burst: BURST_RST, crc: CRC_INIT, lfsr: LFSR_SEED,
		pre_eff: PRE_RST, gap_eff: GAP_RST, gst: G_IDLE,
		drv_mi: PAD_CTRL_RST[MI_DRV_LSB+:2],
		drv_md: PAD_CTRL_RST[MD_DRV_LSB+:2], default: '0};
endpackage
`default_nettype wire

// [verif/mac_partner.sv]
// MAC side model: free transmit clock, nibble sender, pad capture
`default_nettype none
module mac_partner (
	output logic                 tx_clk_o,
	output phy_ext_pkg::mii_tx_t mac_tx_o,
	input  wire phy_ext_pkg::mii_tx_t pad_tx_i
);
	timeunit 1ns;
	timeprecision 1ps;
	import phy_ext_pkg::*;
	logic [3:0] q[$];

	// Free running transmit clock, phase apart from the core clock
	initial begin
		tx_clk_o = 1'b0;
		mac_tx_o = '0;
		#7;
		forever #80 tx_clk_o = ~tx_clk_o;
	end

	// Keeps every enabled nibble seen at the pads
	always @(posedge tx_clk_o) begin
		if (pad_tx_i.en === 1'b1)
			q.push_back(pad_tx_i.d);
	end

	// Sends a word low nibble first; released data shows the inverse
	task automatic send(input logic [15:0] w);
		for (int i = 0; i < 4; i++) begin
			@(posedge tx_clk_o) #2;
			mac_tx_o = '{en: 1'b1, d: w[4*i+:4]};
		end
		@(posedge tx_clk_o) #2;
		mac_tx_o = '{en: 1'b0, d: ~mac_tx_o.d};
	endtask
endmodule
`default_nettype wire

// [verif/tb_phy_ext_control_and_pkt_gen.sv]
// Self-checking bench of the extended control and packet generator
`default_nettype none
module tb_phy_ext_control_and_pkt_gen;
	timeunit 1ns;
	timeprecision 1ps;
	import phy_ext_pkg::*;
	logic        clk_i, rst_b_i, iso, pins_in, scan, link, girq, wev, wack;
	logic        strap, dac, rxs, txc, rxc_o, tx_oe, rx_oe, pin, gate;
	logic        rxchk, txchk;
	logic [1:0]  mi_drv, md_drv;
	logic [15:0] rdata, v;
	logic [47:0] addr;
	reg_req_t    req;
	mii_tx_t     mac_tx, pad_tx;
	int          errors, n_checks, n;
	logic [3:0]  ref_q[$];
	int          wid[4] = '{WAKE_10US_CYC, 50, 100, 200};
	logic [15:0] ofs[9] = '{PAD_CTRL_OFS, CLK_WAKE_OFS, WAKE_HI_OFS,
		WAKE_MID_OFS, WAKE_LO_OFS, SELFTEST_OFS, PKT_LEN_OFS, BURST_OFS,
		16'h4002};
	logic [15:0] rst[9] = '{16'h80ef, 16'h0260, 16'h0000, 16'h0000,
		16'h0000, 16'h68c0, 16'h0040, 16'h0000, 16'h0000};

	phy_ext_control_and_pkt_gen #(
		.WAKE_100US_CYC(50), .WAKE_1MS_CYC(100), .WAKE_10MS_CYC(200)
	) i_dut (
		.clk_i(clk_i), .rst_b_i(rst_b_i), .reg_req_i(req),
		.reg_rdata_o(rdata), .isolate_i(iso), .clk_pins_input_i(pins_in),
		.scan_mode_i(scan), .link_up_i(link), .general_irq_i(girq),
		.wake_event_i(wev), .wake_ack_i(wack),
		.receive_data_bit1_strap_i(strap), .dac_clk_i(dac),
		.rx_clk_src_i(rxs), .tx_clk_i(txc), .mac_tx_i(mac_tx),
		.pad_tx_o(pad_tx), .rx_clk_o(rxc_o), .tx_clk_oe_o(tx_oe),
		.rx_clk_oe_o(rx_oe), .status_light_pin_o(pin),
		.media_if_drive_strength_o(mi_drv),
		.mgmt_pin_drive_strength_o(md_drv), .wake_match_addr_o(addr),
		.rx_checker_en_o(rxchk), .tx_checker_en_o(txchk),
		.selftest_clk_gate_o(gate)
	);

	mac_partner i_mac (.tx_clk_o(txc), .mac_tx_o(mac_tx), .pad_tx_i(pad_tx));

	// Core clock at 50 MHz
	initial begin
		clk_i = 1'b0;
		forever #10 clk_i = ~clk_i;
	end

	// Moves to just after a rising edge
	task automatic step(input int k = 1);
		repeat (k) @(posedge clk_i);
		#2;
	endtask

	task automatic chk(input string s, input logic [47:0] seen, exp);
		n_checks++;
		if (seen !== exp) begin
			errors++;
			$display("unexpected %s expected %h seen %h", s, exp, seen);
		end
	endtask

	task automatic wr(input logic [15:0] a, d);
		req = '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		step();
		req.wr = 1'b0;
		step(); // Idle edge before the next request
	endtask

	task automatic rd(input logic [15:0] a, output logic [15:0] d);
		req = '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
		step();
		req.rd = 1'b0;
		step();
		d = rdata;
	endtask

	task automatic rchk(input string s, input logic [15:0] a, e);
		rd(a, v);
		chk(s, v, e);
	endtask

	task automatic done(input string s);
		$display("test %s done", s);
	endtask

	// Starts the generator, waits for the burst to clear its enable
	task automatic gen_run(input logic [15:0] ctl);
		i_mac.q.delete();
		wr(SELFTEST_OFS, ctl);
		for (int i = 0; i < 300; i++) begin
			rd(SELFTEST_OFS, v);
			if (v[GEN_EN_BIT] === 1'b0)
				break;
		end
		chk("burst end", v[GEN_EN_BIT], 1'b0);
		step(40);
	endtask

	// Preamble with closing delimiter, then four payload bytes
	task automatic frame_chk(input int p, input logic [31:0] pl);
		chk("frame nibbles", i_mac.q.size(), 2 * p + 16);
		for (int i = 0; i < 2 * p - 1; i++)
			chk("preamble", i_mac.q[i], 4'h5);
		chk("delimiter", i_mac.q[2 * p - 1], 4'hd);
		for (int i = 0; i < 8; i++)
			chk("payload", i_mac.q[2 * p + i], pl[4*i+:4]);
	endtask

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// Cuts a hang short
	initial begin
		#1ms;
		errors++;
		tally_and_finish();
	end

	initial begin
		{rst_b_i, iso, pins_in, scan, link, girq, wev, wack} = '0;
		{strap, dac, rxs, req, errors, n_checks} = '0;
		strap = 1'b1;
		dac = 1'b1;
		step(4);
		rst_b_i = 1'b1;
		step(4);
		// Register defaults, unmapped place, address words
		foreach (ofs[i])
			rchk("reset value", ofs[i], rst[i]);
		chk("gate at reset", gate, 1'b1);
		chk("drives at reset", {mi_drv, md_drv}, 4'hb);
		chk("rx clock normal", rxc_o, 1'b0);
		wr(WAKE_HI_OFS, 16'h1234);
		wr(WAKE_MID_OFS, 16'h5678);
		wr(WAKE_LO_OFS, 16'h9abc);
		wr(16'h4002, 16'hffff);
		step();
		chk("wake address", addr, 48'h123456789abc);
		rchk("wake low", WAKE_LO_OFS, 16'h9abc);
		rchk("unmapped", 16'h4002, 16'h0000);
		done("registers");
		// Drive strengths, wake pulse widths, wake level, general source
		wr(PAD_CTRL_OFS, 16'h00db);
		step();
		chk("drives", {mi_drv, md_drv}, 4'h6);
		scan = 1'b1;
		step(2);
		chk("scan drives", {mi_drv, md_drv}, 4'hb);
		scan = 1'b0;
		for (int k = 0; k < 4; k++) begin
			wr(CLK_WAKE_OFS, 16'h00e0 | (16'(k) << 8));
			wev = 1'b1;
			step();
			wev = 1'b0;
			step();
			n = 0;
			while (pin === 1'b1 && n < 1000) begin
				n++;
				step();
			end
			chk("pulse width", n, wid[k]);
		end
		wr(CLK_WAKE_OFS, 16'h0060);
		wev = 1'b1;
		step();
		wev = 1'b0;
		step(10);
		chk("wake level", pin, 1'b1);
		wack = 1'b1;
		step();
		wack = 1'b0;
		step(3);
		chk("level cleared", pin, 1'b0);
		wr(PAD_CTRL_OFS, 16'h80ef);
		girq = 1'b1;
		step(3);
		chk("general high", pin, 1'b1);
		girq = 1'b0;
		step(3);
		chk("general low", pin, 1'b0);
		done("wake");
		// Isolate directions and jitter clock mux
		wr(CLK_WAKE_OFS, 16'h4040);
		iso = 1'b1;
		step(3);
		chk("tx clock dir", tx_oe, 1'b0);
		chk("rx clock dir", rx_oe, 1'b1);
		chk("jitter mux", rxc_o, 1'b1);
		pins_in = 1'b1;
		step(2);
		chk("rx clock kept", rx_oe, 1'b1);
		pins_in = 1'b0;
		iso = 1'b0;
		done("clocks");
		// Checkers, gating, MAC data path
		wr(SELFTEST_OFS, 16'he8c0);
		step(2);
		chk("checkers on", {rxchk, txchk, gate}, 3'h6);
		wr(SELFTEST_OFS, 16'h28c0);
		step(2);
		chk("checkers off", {rxchk, txchk, gate}, 3'h0);
		i_mac.q.delete();
		i_mac.send(16'h4321);
		step(20);
		chk("mac nibbles", i_mac.q.size(), 4);
		for (int i = 0; i < 4; i++)
			chk("mac path", i_mac.q[i], 4'(i + 1));
		done("mac path");
		// Generator: link, force, burst, preamble, corrupt, payloads
		wr(PKT_LEN_OFS, 16'h0004);
		wr(BURST_OFS, 16'h0001);
		i_mac.q.delete();
		wr(SELFTEST_OFS, 16'h13c2);
		step(300);
		chk("no link", i_mac.q.size(), 0);
		gen_run(16'h13ca);
		rchk("self clear", SELFTEST_OFS, 16'h03ca);
		frame_chk(3, 32'ha55aa55a);
		ref_q = i_mac.q;
		gen_run(16'h11ce);
		frame_chk(3, 32'ha55aa55a);
		chk("bad fcs", i_mac.q[14], 4'(~ref_q[14]));
		chk("fcs tail", i_mac.q[21], ref_q[21]);
		link = 1'b1;
		gen_run(16'h13c0);
		frame_chk(3, 32'h03020100);
		gen_run(16'h13c1);
		frame_chk(3, 32'h08040201);
		wr(BURST_OFS, 16'h0000);
		wr(SELFTEST_OFS, 16'h13c0);
		step(600);
		rchk("continuous", SELFTEST_OFS, 16'h13c0);
		wr(SELFTEST_OFS, 16'h03c0);
		step(400);
		i_mac.q.delete();
		step(200);
		chk("stopped", i_mac.q.size(), 0);
		done("generator");
		tally_and_finish();
	end
endmodule
`default_nettype wire
